// >>> logic/clock_source_control.sv
// Clock source control register block with APB slave and event interrupt.
// Assumes all inputs synchronous to clock; tick inputs pulse once per
// oscillator cycle; mode and failure inputs are one-cycle pulses.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "clock_source_control_map.svh"
// Behaviour
// - PLL ready flag in bit 25 reflects lock; read-only to software.
// - Entering low-power-run, stop or power-down clears PLL and external enables.
// - Software clear of PLL enable ignored while PLL drives system clock.
// - PLL output passes only while PLL output enable bit 23 is one.
// - Bypass bit 22 selects PLL input clock instead of multiplied clock.
// - Clock failure detector active only with bit 19 set and external ready.
// - External bypass bit 18 writable only while external oscillator disabled.
// - External ready flag bit 17 drops 6 oscillator cycles after enable clear.
// - Software clear of external enable ignored while it drives system clock.
// - Five-bit internal trim in bits 7:3, writable, reset value 16.
// - Internal ready flag bit 1 drops 6 oscillator cycles after enable clear.
// - Software clear of internal enable ignored while it drives system clock.
// - Internal enable forced on at low-power exit and on external failure.
module clock_source_control
(
   input  wire logic                         clock,
   input  wire logic                         sys_rst,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [31:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire clock_source_control_pkg::sys_clk_src_t sys_clk_src,
   input  wire logic                         low_power_entry,
   input  wire logic                         low_power_exit,
   input  wire logic                         ext_osc_fail,
   input  wire logic                         int_osc_stable,
   input  wire logic                         int_osc_tick,
   input  wire logic                         ext_osc_stable,
   input  wire logic                         ext_osc_tick,
   input  wire logic                         pll_locked,
   output logic                              int_osc_enable,
   output logic      [4:0]                   int_osc_trim,
   output logic                              ext_osc_enable,
   output logic                              ext_osc_bypass,
   output logic                              pll_enable,
   output logic                              pll_output_enable,
   output logic                              pll_bypass,
   output logic                              clock_detector_active,
   output logic                              irq
);

   // ======================================================
   // Bus decode
   logic                   access_done;
   logic                   wr_en;
   logic [`CSC_ADDR_W-1:0] addr;
   logic                   hit_ctrl;
   logic                   hit_status;
   logic                   hit_mask;
   logic                   mapped;

   // One wait state: pready rises in the second access cycle
   assign access_done = psel && penable && pready;
   assign wr_en       = access_done && pwrite && mapped;
   assign addr        = paddr[`CSC_ADDR_W-1:0];
   assign hit_ctrl    = (addr == `CSC_OFF_CTRL);
   assign hit_status  = (addr == `CSC_OFF_STATUS);
   assign hit_mask    = (addr == `CSC_OFF_MASK);
   assign mapped      = (paddr[31:`CSC_ADDR_W] == 24'h000000) &&
                        (hit_ctrl || hit_status || hit_mask);

   // ======================================================
   // Control register state
   logic       int_en_q;
   logic [4:0] trim_q;
   logic       ext_en_q;
   logic       ext_bp_q;
   logic       css_en_q;
   logic       pll_en_q;
   logic       pll_oe_q;
   logic       pll_bp_q;
   logic       pll_rdy_q;
   logic       css_act_q;
   logic       ctrl_wr;
   logic       int_en_d;
   logic       ext_en_d;
   logic       pll_en_d;

   assign ctrl_wr = wr_en && hit_ctrl;

   // Hardware set or clear outranks software; a low-power request wins
   // over the lock against turning off the running source.
   always_comb
   begin
      int_en_d = int_en_q;
      if (ctrl_wr)
      begin
         int_en_d = pwdata[`CSC_INT_EN_BIT] ||
                    (sys_clk_src == clock_source_control_pkg::src_int_osc);
      end
      if (low_power_exit || ext_osc_fail)
      begin
         int_en_d = 1'b1;
      end
   end

   always_comb
   begin
      ext_en_d = ext_en_q;
      if (ctrl_wr)
      begin
         ext_en_d = pwdata[`CSC_EXT_EN_BIT] ||
                    (sys_clk_src == clock_source_control_pkg::src_ext_osc);
      end
      if (low_power_entry)
      begin
         ext_en_d = 1'b0;
      end
   end

   always_comb
   begin
      pll_en_d = pll_en_q;
      if (ctrl_wr)
      begin
         pll_en_d = pwdata[`CSC_PLL_EN_BIT] ||
                    (sys_clk_src == clock_source_control_pkg::src_pll);
      end
      if (low_power_entry)
      begin
         pll_en_d = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         int_en_q <= `CSC_INT_EN_RESET;
         ext_en_q <= 1'b0;
         pll_en_q <= 1'b0;
      end
      else
      begin
         int_en_q <= int_en_d;
         ext_en_q <= ext_en_d;
         pll_en_q <= pll_en_d;
      end
   end

   // Plain software fields; ready flags and reserved bits are not stored
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         trim_q   <= `CSC_TRIM_RESET;
         css_en_q <= 1'b0;
         pll_oe_q <= 1'b0;
         pll_bp_q <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         trim_q   <= pwdata[`CSC_TRIM_MSB:`CSC_TRIM_LSB];
         css_en_q <= pwdata[`CSC_CSS_EN_BIT];
         pll_oe_q <= pwdata[`CSC_PLL_OUT_EN_BIT];
         pll_bp_q <= pwdata[`CSC_PLL_BYPASS_BIT];
      end
   end

   // Bypass may only change while the oscillator is off, else the pad mode
   // would switch under a running crystal.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         ext_bp_q <= 1'b0;
      end
      else if (ctrl_wr && !ext_en_q)
      begin
         ext_bp_q <= pwdata[`CSC_EXT_BYPASS_BIT];
      end
   end

   // ======================================================
   // Ready tracking
   ready_track_if int_trk ();
   ready_track_if ext_trk ();

   assign int_trk.enable = int_en_q;
   assign int_trk.stable = int_osc_stable;
   assign int_trk.tick   = int_osc_tick;
   assign ext_trk.enable = ext_en_q;
   assign ext_trk.stable = ext_osc_stable;
   assign ext_trk.tick   = ext_osc_tick;

   osc_ready_tracker #(.DRAIN_TICKS(`CSC_DRAIN_TICKS)) u_int_ready
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .trk     (int_trk)
   );

   osc_ready_tracker #(.DRAIN_TICKS(`CSC_DRAIN_TICKS)) u_ext_ready
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .trk     (ext_trk)
   );

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         pll_rdy_q <= 1'b0;
      end
      else
      begin
         pll_rdy_q <= pll_en_q && pll_locked;
      end
   end

   // Detector waits for ready, or it would flag a crystal still starting
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         css_act_q <= 1'b0;
      end
      else
      begin
         css_act_q <= css_en_q && ext_trk.ready;
      end
   end

   // ======================================================
   // Events and interrupt
   logic [`CSC_EV_W-1:0] status_q;
   logic [`CSC_EV_W-1:0] mask_q;
   logic [`CSC_EV_W-1:0] events;
   logic                 int_rdy_prev_q;
   logic                 ext_rdy_prev_q;
   logic                 pll_rdy_prev_q;
   logic [`CSC_EV_W-1:0] status_clr;
   logic                 irq_q;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         int_rdy_prev_q <= 1'b0;
         ext_rdy_prev_q <= 1'b0;
         pll_rdy_prev_q <= 1'b0;
      end
      else
      begin
         int_rdy_prev_q <= int_trk.ready;
         ext_rdy_prev_q <= ext_trk.ready;
         pll_rdy_prev_q <= pll_rdy_q;
      end
   end

   always_comb
   begin
      events                      = '0;
      events[`CSC_EV_INT_READY]   = int_trk.ready && !int_rdy_prev_q;
      events[`CSC_EV_EXT_READY]   = ext_trk.ready && !ext_rdy_prev_q;
      events[`CSC_EV_PLL_READY]   = pll_rdy_q && !pll_rdy_prev_q;
      events[`CSC_EV_EXT_FAIL]    = ext_osc_fail;
   end

   assign status_clr = (wr_en && hit_status) ? pwdata[`CSC_EV_W-1:0] : '0;

   // New event wins over a clear in the same cycle
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         status_q <= '0;
      end
      else
      begin
         status_q <= (status_q & ~status_clr) | events;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         mask_q <= '0;
      end
      else if (wr_en && hit_mask)
      begin
         mask_q <= pwdata[`CSC_EV_W-1:0];
      end
   end

   // Registered, so irq trails the status bit by one cycle
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(status_q & mask_q);
      end
   end

   // ======================================================
   // Read path and handshake
   logic [31:0] ctrl_view;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic        ready_q;
   logic        err_q;

   always_comb
   begin
      ctrl_view                              = 32'h00000000;
      ctrl_view[`CSC_PLL_READY_BIT]          = pll_rdy_q;
      ctrl_view[`CSC_PLL_EN_BIT]             = pll_en_q;
      ctrl_view[`CSC_PLL_OUT_EN_BIT]         = pll_oe_q;
      ctrl_view[`CSC_PLL_BYPASS_BIT]         = pll_bp_q;
      ctrl_view[`CSC_CSS_EN_BIT]             = css_en_q;
      ctrl_view[`CSC_EXT_BYPASS_BIT]         = ext_bp_q;
      ctrl_view[`CSC_EXT_READY_BIT]          = ext_trk.ready;
      ctrl_view[`CSC_EXT_EN_BIT]             = ext_en_q;
      ctrl_view[`CSC_TRIM_MSB:`CSC_TRIM_LSB] = trim_q;
      ctrl_view[`CSC_INT_READY_BIT]          = int_trk.ready;
      ctrl_view[`CSC_INT_EN_BIT]             = int_en_q;
   end

   always_comb
   begin
      rdata_d = 32'h00000000;
      if (hit_ctrl)
      begin
         rdata_d = ctrl_view;
      end
      else if (hit_status)
      begin
         rdata_d[`CSC_EV_W-1:0] = status_q;
      end
      else if (hit_mask)
      begin
         rdata_d[`CSC_EV_W-1:0] = mask_q;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         ready_q <= 1'b0;
         err_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         ready_q <= psel && penable && !ready_q;
         err_q   <= psel && penable && !ready_q && !mapped;
         if (psel && penable && !ready_q && !pwrite && mapped)
         begin
            rdata_q <= rdata_d;
         end
         else
         begin
            rdata_q <= 32'h00000000;
         end
      end
   end

   // ======================================================
   // Outputs
   assign prdata                = rdata_q;
   assign pready                = ready_q;
   assign pslverr               = err_q;
   assign irq                   = irq_q;
   assign int_osc_enable        = int_en_q;
   assign int_osc_trim          = trim_q;
   assign ext_osc_enable        = ext_en_q;
   assign ext_osc_bypass        = ext_bp_q;
   assign pll_enable            = pll_en_q;
   assign pll_output_enable     = pll_oe_q;
   assign pll_bypass            = pll_bp_q;
   assign clock_detector_active = css_act_q;

endmodule : clock_source_control

// >>> logic/osc_ready_tracker.sv
// Ready flag of one clock source: raised when the source is enabled and stable,
// dropped after a fixed number of source cycles once the enable goes low.
// Assumes tick pulses are synchronous to clock, one per source cycle.
`timescale 1ns/1ps
`include "clock_source_control_map.svh"
module osc_ready_tracker
#(
   parameter int unsigned DRAIN_TICKS = `CSC_DRAIN_TICKS
)
(
   input  wire logic           clock,
   input  wire logic           sys_rst,
   ready_track_if.tracker      trk
);

   // ======================================================
   // State
   clock_source_control_pkg::osc_state_t state_q;
   logic [3:0]                           drain_cnt_q;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state_q     <= clock_source_control_pkg::osc_off;
         drain_cnt_q <= 4'h0;
      end
      else
      begin
         case (state_q)
            clock_source_control_pkg::osc_off:
            begin
               if (trk.enable)
               begin
                  state_q <= clock_source_control_pkg::osc_starting;
               end
            end
            clock_source_control_pkg::osc_starting:
            begin
               if (!trk.enable)
               begin
                  state_q <= clock_source_control_pkg::osc_off;
               end
               else if (trk.stable)
               begin
                  state_q <= clock_source_control_pkg::osc_ready;
               end
            end
            clock_source_control_pkg::osc_ready:
            begin
               drain_cnt_q <= 4'h0;
               if (!trk.enable)
               begin
                  state_q <= clock_source_control_pkg::osc_draining;
               end
            end
            clock_source_control_pkg::osc_draining:
            begin
               // Flag stays up until the source has really wound down
               if (trk.enable)
               begin
                  state_q <= clock_source_control_pkg::osc_ready;
               end
               else if (trk.tick)
               begin
                  if (drain_cnt_q == 4'(DRAIN_TICKS - 1))
                  begin
                     state_q <= clock_source_control_pkg::osc_off;
                  end
                  drain_cnt_q <= drain_cnt_q + 4'h1;
               end
            end
            default:
            begin
               state_q <= clock_source_control_pkg::osc_off;
            end
         endcase
      end
   end

   assign trk.ready = (state_q == clock_source_control_pkg::osc_ready) ||
                      (state_q == clock_source_control_pkg::osc_draining);

endmodule : osc_ready_tracker

// >>> shared/clock_source_control_map.svh
// Offsets, field positions, reset values and counts of the clock source control block.
// Assumes inclusion by bare name from the logic files.
`ifndef CLOCK_SOURCE_CONTROL_MAP_SVH
`define CLOCK_SOURCE_CONTROL_MAP_SVH

// ======================================================
// Register offsets
`define CSC_ADDR_W          8
`define CSC_OFF_CTRL        8'h00
`define CSC_OFF_STATUS      8'h10
`define CSC_OFF_MASK        8'h14

// ======================================================
// Control register fields
`define CSC_PLL_READY_BIT   25
`define CSC_PLL_EN_BIT      24
`define CSC_PLL_OUT_EN_BIT  23
`define CSC_PLL_BYPASS_BIT  22
`define CSC_CSS_EN_BIT      19
`define CSC_EXT_BYPASS_BIT  18
`define CSC_EXT_READY_BIT   17
`define CSC_EXT_EN_BIT      16
`define CSC_TRIM_MSB        7
`define CSC_TRIM_LSB        3
`define CSC_INT_READY_BIT   1
`define CSC_INT_EN_BIT      0
`define CSC_TRIM_RESET      5'h10
`define CSC_INT_EN_RESET    1'b1

// ======================================================
// Status and mask fields
`define CSC_EV_W            4
`define CSC_EV_INT_READY    0
`define CSC_EV_EXT_READY    1
`define CSC_EV_PLL_READY    2
`define CSC_EV_EXT_FAIL     3

// ======================================================
// Oscillator cycles from enable clear to ready low
`define CSC_DRAIN_TICKS     6

`endif

// >>> shared/clock_source_control_pkg.sv
// Types shared by the clock source control logic.
// Assumes compilation before the logic and verification files that use its types.
package clock_source_control_pkg;

   // ======================================================
   // System clock source as reported by the clock switch
   typedef enum logic [1:0]
   {
      src_int_osc = 2'h0,
      src_ext_osc = 2'h1,
      src_pll     = 2'h2
   } sys_clk_src_t;

   // ======================================================
   // Oscillator ready tracking states
   typedef enum logic [1:0]
   {
      osc_off,
      osc_starting,
      osc_ready,
      osc_draining
   } osc_state_t;

endpackage : clock_source_control_pkg

// >>> shared/ready_track_if.sv
// Enable, stability and ready signals between the control logic and a ready tracker.
// Assumes one clock domain; tick is a one-cycle pulse per oscillator cycle.
`timescale 1ns/1ps
interface ready_track_if;
   logic enable;
   logic stable;
   logic tick;
   logic ready;

   modport tracker
   (
      input  enable,
      input  stable,
      input  tick,
      output ready
   );

   modport owner
   (
      output enable,
      output stable,
      output tick,
      input  ready
   );
endinterface : ready_track_if

// >>> verif/clock_source_control_assertions.sv
// Concurrent checks on the top ports of the clock source control block.
// Assumes it is bound onto clock_source_control from the bench top file.
`timescale 1ns/1ps
module clock_source_control_assertions
(
   input wire logic                                   clock,
   input wire logic                                   sys_rst,
   input wire logic                                   psel,
   input wire logic                                   penable,
   input wire logic                                   pwrite,
   input wire logic [31:0]                            paddr,
   input wire logic [31:0]                            prdata,
   input wire logic                                   pready,
   input wire logic                                   pslverr,
   input wire clock_source_control_pkg::sys_clk_src_t sys_clk_src,
   input wire logic                                   low_power_entry,
   input wire logic                                   low_power_exit,
   input wire logic                                   ext_osc_fail,
   input wire logic                                   int_osc_enable,
   input wire logic [4:0]                             int_osc_trim,
   input wire logic                                   ext_osc_enable,
   input wire logic                                   ext_osc_bypass,
   input wire logic                                   pll_enable,
   input wire logic                                   pll_output_enable,
   input wire logic                                   pll_bypass
);
   // ======================================================
   // Helpers
   logic ctrl_wr;
   assign ctrl_wr = psel && penable && pready && pwrite && (paddr == 32'h0000_0000);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // ======================================================
   // Bus answer
   property p_apb_wait;
      psel && $rose(penable) |=> pready ##1 !pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("pready not one pulse after one wait");
   property p_apb_err;
      pready |-> (pslverr == !(paddr inside {32'h0000_0000, 32'h0000_0010, 32'h0000_0014}));
   endproperty
   a_apb_err: assert property (p_apb_err) else $error("pslverr wrong for address");
   property p_rdata_idle;
      !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata nonzero outside answer");

   // ======================================================
   // Control fields
   property p_trim_hold;
      !ctrl_wr |=> $stable(int_osc_trim);
   endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("trim changed without write");
   property p_pll_cfg_hold;
      !ctrl_wr |=> $stable({pll_output_enable, pll_bypass});
   endproperty
   a_pll_cfg_hold: assert property (p_pll_cfg_hold) else $error("pll gate changed");
   property p_bypass_lock;
      ext_osc_enable |=> $stable(ext_osc_bypass);
   endproperty
   a_bypass_lock: assert property (p_bypass_lock) else $error("bypass changed while on");

   // ======================================================
   // Hardware forcing and running-source locks
   property p_entry;
      low_power_entry |=> !pll_enable && !ext_osc_enable;
   endproperty
   a_entry: assert property (p_entry) else $error("enables kept on mode entry");
   property p_wake;
      low_power_exit || ext_osc_fail |=> int_osc_enable;
   endproperty
   a_wake: assert property (p_wake) else $error("internal enable not forced");
   property p_pll_lock;
      pll_enable && sys_clk_src == clock_source_control_pkg::src_pll && !low_power_entry
      |=> pll_enable;
   endproperty
   a_pll_lock: assert property (p_pll_lock) else $error("running pll disabled");
   property p_ext_lock;
      ext_osc_enable && sys_clk_src == clock_source_control_pkg::src_ext_osc && !low_power_entry
      |=> ext_osc_enable;
   endproperty
   a_ext_lock: assert property (p_ext_lock) else $error("running external disabled");
   property p_int_lock;
      int_osc_enable && sys_clk_src == clock_source_control_pkg::src_int_osc |=> int_osc_enable;
   endproperty
   a_int_lock: assert property (p_int_lock) else $error("running internal disabled");
endmodule : clock_source_control_assertions

// >>> verif/clock_source_control_tb.sv
// Self-checking bench for the clock source control block over APB.
// Assumes the checker file is compiled before it; ticks pulse every other cycle.
`timescale 1ns/1ps
module clock_source_control_tb;
   // ======================================================
   // Signals
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdata;
   logic        pready, pslverr, rerr, irq, clock_detector_active;
   clock_source_control_pkg::sys_clk_src_t sys_clk_src = clock_source_control_pkg::src_int_osc;
   logic        low_power_entry = 1'b0, low_power_exit = 1'b0, ext_osc_fail = 1'b0;
   logic        int_osc_stable = 1'b1, int_osc_tick = 1'b0, ext_osc_stable = 1'b0;
   logic        ext_osc_tick = 1'b0, pll_locked = 1'b0;
   logic        int_osc_enable, ext_osc_enable, ext_osc_bypass;
   logic        pll_enable, pll_output_enable, pll_bypass;
   logic [4:0]  int_osc_trim;
   int          num_errors = 0;
   int          cmp_count = 0;

   always #20 clock = ~clock;
   // Both oscillators tick at half the bus rate, so 6 ticks span 12 cycles
   always @(posedge clock)
   begin
      int_osc_tick <= ~int_osc_tick;
      ext_osc_tick <= ~ext_osc_tick;
   end

   clock_source_control clock_source_control_i
   (
      .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sys_clk_src(sys_clk_src), .low_power_entry(low_power_entry),
      .low_power_exit(low_power_exit), .ext_osc_fail(ext_osc_fail),
      .int_osc_stable(int_osc_stable), .int_osc_tick(int_osc_tick),
      .ext_osc_stable(ext_osc_stable), .ext_osc_tick(ext_osc_tick), .pll_locked(pll_locked),
      .int_osc_enable(int_osc_enable), .int_osc_trim(int_osc_trim),
      .ext_osc_enable(ext_osc_enable), .ext_osc_bypass(ext_osc_bypass),
      .pll_enable(pll_enable), .pll_output_enable(pll_output_enable),
      .pll_bypass(pll_bypass), .clock_detector_active(clock_detector_active), .irq(irq)
   );

   // ======================================================
   // Tasks
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Request held until pready seen; next call waits a fresh edge, so no double drive
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   task pulse(input logic [2:0] v);
      @(posedge clock);
      {low_power_entry, low_power_exit, ext_osc_fail} <= v;
      @(posedge clock);
      {low_power_entry, low_power_exit, ext_osc_fail} <= 3'h0;
      #1;
   endtask : pulse

   task src(input clock_source_control_pkg::sys_clk_src_t s);
      @(posedge clock);
      sys_clk_src <= s;
      #1;
   endtask : src

   task idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : idle

   task end_of_test;
      if (num_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // ======================================================
   // Watchdog
   initial
   begin
      repeat (5000) @(posedge clock);
      num_errors++;
      end_of_test();
   end

   // ======================================================
   // Scenarios
   initial
   begin
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      idle(6);
      apb(1'b0, 32'h00, 32'h0);
      chk("ctrl_reset", 32'h0000_0083, rdata);
      apb(1'b1, 32'h10, 32'hf);
      apb(1'b0, 32'h10, 32'h0);
      chk("status_clear", 32'h0, rdata);
      // Ready positions written high must not stick; reserved kept at zero
      apb(1'b1, 32'h00, 32'h03cf_00fb);
      apb(1'b0, 32'h00, 32'h0);
      chk("ctrl_ones", 32'h01cd_00fb, rdata);
      chk("ctrl_outs", {24'h0, 3'h7, 5'h1f}, {pll_output_enable, pll_bypass, ext_osc_bypass, int_osc_trim});
      @(posedge clock);
      ext_osc_stable <= 1'b1;
      pll_locked <= 1'b1;
      idle(6);
      apb(1'b0, 32'h00, 32'h0);
      chk("ctrl_ready", 32'h03cf_00fb, rdata);
      chk("detector_on", 32'h1, {31'h0, clock_detector_active});
      apb(1'b0, 32'h10, 32'h0);
      chk("status_rise", 32'h6, rdata);
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, 32'h14, 32'h4);
      idle(2);
      chk("irq_raised", 32'h1, {31'h0, irq});
      apb(1'b1, 32'h10, 32'h4);
      idle(2);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      apb(1'b1, 32'h00, 32'h01c1_0081);
      idle(2);
      chk("detector_off", 32'h0, {31'h0, clock_detector_active});
      apb(1'b0, 32'h00, 32'h0);
      chk("bypass_locked", 32'h03c7_0083, rdata);
      src(clock_source_control_pkg::src_pll);
      apb(1'b1, 32'h00, 32'h0000_0080);
      apb(1'b0, 32'h00, 32'h0);
      chk("drain_early", 32'h0306_0082, rdata);
      idle(14);
      apb(1'b0, 32'h00, 32'h0);
      chk("drain_done", 32'h0304_0080, rdata);
      apb(1'b1, 32'h00, 32'h0100_0080);
      chk("bypass_free", 32'h0, {31'h0, ext_osc_bypass});
      pulse(3'h2);
      chk("wake_exit", 32'h1, {31'h0, int_osc_enable});
      apb(1'b1, 32'h00, 32'h0100_0080);
      chk("int_off", 32'h0, {31'h0, int_osc_enable});
      pulse(3'h1);
      chk("wake_fail", 32'h1, {31'h0, int_osc_enable});
      apb(1'b0, 32'h10, 32'h0);
      chk("status_fail", 32'h8, rdata & 32'h8);
      src(clock_source_control_pkg::src_int_osc);
      apb(1'b1, 32'h00, 32'h0101_0080);
      chk("int_locked", 32'h1, {31'h0, int_osc_enable});
      src(clock_source_control_pkg::src_ext_osc);
      apb(1'b1, 32'h00, 32'h0100_0081);
      chk("ext_locked", 32'h1, {31'h0, ext_osc_enable});
      pulse(3'h4);
      chk("entry_clear", 32'h0, {30'h0, pll_enable, ext_osc_enable});
      apb(1'b0, 32'h20, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, rerr});
      chk("unmapped_data", 32'h0, rdata);
      end_of_test();
   end
endmodule : clock_source_control_tb

bind clock_source_control clock_source_control_assertions clock_source_control_assertions_i
(
   .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sys_clk_src(sys_clk_src), .low_power_entry(low_power_entry),
   .low_power_exit(low_power_exit), .ext_osc_fail(ext_osc_fail),
   .int_osc_enable(int_osc_enable), .int_osc_trim(int_osc_trim),
   .ext_osc_enable(ext_osc_enable), .ext_osc_bypass(ext_osc_bypass),
   .pll_enable(pll_enable), .pll_output_enable(pll_output_enable), .pll_bypass(pll_bypass)
);
